/* File: hdl/sfam_defines.svh */
// Purpose: constants for the special function register area decoder
// Assumes: 8-bit register addresses, 16-bit external data addresses
// Notes: Functional notes follow
`ifndef SFAM_DEFINES_SVH
`define SFAM_DEFINES_SVH

`define SFAM_SYSCTL_ADDR 8'hB1
`define SFAM_MAP_BIT 4
`define SFAM_SWO_BIT 2
`define SFAM_SYSCTL_RESET 8'h21
`define SFAM_SYSCTL_WMASK 8'h3F
`define SFAM_CAN_BASE 16'hF700
`define SFAM_CAN_LAST 16'hF7FF
`define SFAM_MAPPED_COUNT 5
`define SFAM_TOTAL_COUNT 52
`define SFAM_STD_COUNT 47
`define SFAM_PCON2_ADDR 8'h88
`define SFAM_ANASEL_ADDR 8'h90
`define SFAM_VER0_ADDR 8'hFC
`define SFAM_VER1_ADDR 8'hFD
`define SFAM_VER2_ADDR 8'hFE

`endif

/* File: hdl/sfam_pkg.sv */
// Purpose: types for the special function register area decoder
// Assumes: nothing beyond the defines header
// Notes: the area enum is one-hot
package sfam_pkg;
    typedef enum logic [2:0] {
        SFAM_AREA_NONE = 3'h1,
        SFAM_AREA_STD = 3'h2,
        SFAM_AREA_MAP = 3'h4
    } sfam_area_e;
    typedef logic [7:0] sfam_byte_t;
endpackage : sfam_pkg

/* File: hdl/sfam_bit_access.sv */
// Purpose: merges a single-bit write into a byte and extracts a read bit
// Assumes: bit index valid only with a bit access
// Notes: used only on the system control register, which is not bit-addressable
`timescale 1ns/1ps
`default_nettype none
module sfam_bit_access
    import sfam_pkg::*;
(
    // current byte and access
    input wire logic [7:0] curByte,
    input wire logic [7:0] wrByte,
    input wire logic bitMode,
    input wire logic [2:0] bitIndex,
    input wire logic bitValue,
    // results
    output logic [7:0] mergedByte,
    output logic readBit
);
    wire [7:0] bitMask = 8'h01 << bitIndex;
    // read-modify-write keeps neighbour bits intact
    assign mergedByte = bitMode ? ((curByte & ~bitMask) | ({8{bitValue}} & bitMask)) : wrByte;
    assign readBit = curByte[bitIndex];
endmodule : sfam_bit_access
`default_nettype wire

/* File: hdl/sfam_decoder.sv */
// Purpose: special function register area select, system control register, can window decode
// Assumes: cpu core presents one access per cycle on sys_clk
// Notes: peripheral registers live elsewhere; this block decodes and selects, and holds only the system control register and read data
`timescale 1ns/1ps
`default_nettype none
`include "sfam_defines.svh"
module sfam_decoder
    import sfam_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // special function register access from the core
    input wire logic sfrRd,
    input wire logic sfrWr,
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrWdata,
    input wire logic sfrBitMode,
    input wire logic [2:0] sfrBitIndex,
    input wire logic sfrBitValue,
    output logic [7:0] sfrRdata,
    output logic sfrBitRdata,
    output logic sfrBitError,
    // read data returned by the two areas
    input wire logic [7:0] stdRdata,
    input wire logic [7:0] mapRdata,
    // area strobes
    output logic stdSel,
    output logic mapSel,
    output logic [2:0] mapIndex,
    output logic [2:0] areaSel,
    // external data space
    input wire logic xdataReq,
    input wire logic [15:0] xdataAddr,
    output logic canSel,
    output logic [7:0] canOffset,
    // system control outputs
    output logic mapAreaSelect,
    output logic canSwitchOff,
    output logic [7:0] systemControl
);
    logic [7:0] system_control_reg;
    logic [7:0] system_control_next;
    logic [7:0] rdataReg;
    logic bitRdReg;
    wire access = sfrRd | sfrWr;
    wire hitSysCtl = sfrAddr == `SFAM_SYSCTL_ADDR;
    // bit access is legal only where the low three address bits are zero
    wire bitAddressable = sfrAddr[2:0] == 3'h0;
    wire mapBit = system_control_reg[`SFAM_MAP_BIT];
    wire hitPcon2 = sfrAddr == `SFAM_PCON2_ADDR;
    wire hitAnasel = sfrAddr == `SFAM_ANASEL_ADDR;
    wire hitVer0 = sfrAddr == `SFAM_VER0_ADDR;
    wire hitVer1 = sfrAddr == `SFAM_VER1_ADDR;
    wire hitVer2 = sfrAddr == `SFAM_VER2_ADDR;
    // exactly five mapped locations
    wire mapHit = hitPcon2 | hitAnasel | hitVer0 | hitVer1 | hitVer2;
    // the control register stays reachable in both areas so software can switch back
    wire mapped = mapBit & mapHit & ~hitSysCtl;
    wire sysCtlHit = access & hitSysCtl;
    wire [7:0] merged;
    wire bitBad = sfrBitMode & ~bitAddressable;

    sfam_bit_access u_bit (
        .curByte(system_control_reg),
        .wrByte(sfrWdata),
        .bitMode(sfrBitMode),
        .bitIndex(sfrBitIndex),
        .bitValue(sfrBitValue),
        .mergedByte(merged),
        .readBit()
    );

    assign mapIndex = hitPcon2 ? 3'h0
        : hitAnasel ? 3'h1
        : hitVer0 ? 3'h2
        : hitVer1 ? 3'h3
        : 3'h4;
    assign mapSel = access & mapped & ~bitBad;
    assign stdSel = access & ~mapped & ~hitSysCtl & ~bitBad;
    // each access lands in one area or is refused; a refused bit access to the control register still shows the standard area
    assign areaSel = mapSel ? SFAM_AREA_MAP : (stdSel | sysCtlHit) ? SFAM_AREA_STD : SFAM_AREA_NONE;
    assign sfrBitError = access & bitBad;
    // reserved bits 7:6 stay at reset; only a write changes the register
    assign system_control_next = (sfrWr & hitSysCtl & ~bitBad)
        ? ((merged & `SFAM_SYSCTL_WMASK) | (system_control_reg & ~`SFAM_SYSCTL_WMASK))
        : system_control_reg;
    wire [7:0] rdSrc = hitSysCtl ? system_control_reg : mapped ? mapRdata : stdRdata;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            system_control_reg <= `SFAM_SYSCTL_RESET;
        end else begin
            system_control_reg <= system_control_next;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rdataReg <= 8'h00;
            bitRdReg <= 1'b0;
        end else if (sfrRd & ~bitBad) begin
            rdataReg <= rdSrc;
            bitRdReg <= rdSrc[sfrBitIndex];
        end
    end

    assign sfrRdata = rdataReg;
    assign sfrBitRdata = bitRdReg;
    assign mapAreaSelect = mapBit;
    assign canSwitchOff = system_control_reg[`SFAM_SWO_BIT];
    assign systemControl = system_control_reg;
    // can window sits in external data space only
    assign canSel = xdataReq & (xdataAddr >= `SFAM_CAN_BASE) & (xdataAddr <= `SFAM_CAN_LAST);
    assign canOffset = xdataAddr[7:0];

    a_map_route: assert property (
        @(posedge sys_clk) disable iff (reset)
        (access & mapBit & mapHit & ~sfrBitMode)
        |-> (mapSel & ~stdSel))
        else $error("mapped access not routed to mapped area");

    a_std_route: assert property (
        @(posedge sys_clk) disable iff (reset)
        (access & ~mapBit & ~hitSysCtl & ~sfrBitMode)
        |-> (stdSel & ~mapSel))
        else $error("standard access misrouted");

    a_select_holds: assert property (
        @(posedge sys_clk) disable iff (reset)
        !(sfrWr & hitSysCtl)
        |=> $stable(mapAreaSelect))
        else $error("select bit changed without write");

    a_map_count: assert property (
        @(posedge sys_clk) disable iff (reset)
        mapSel
        |-> $onehot({hitPcon2, hitAnasel, hitVer0, hitVer1, hitVer2}))
        else $error("mapped hit outside five registers");

    a_bit_write: assert property (
        @(posedge sys_clk) disable iff (reset)
        (sfrWr & hitSysCtl & sfrBitMode)
        |=> $stable(systemControl))
        else $error("bit write to control register not refused");

    a_refused_quiet: assert property (
        @(posedge sys_clk) disable iff (reset)
        sfrBitError
        |-> !(stdSel | mapSel))
        else $error("refused bit access raised a strobe");

    a_bit_read: assert property (
        @(posedge sys_clk) disable iff (reset)
        (sfrRd & sfrBitMode & bitAddressable)
        |=> (sfrBitRdata == sfrRdata[$past(sfrBitIndex)]))
        else $error("bit read returned wrong bit");

    a_rdata_hold: assert property (
        @(posedge sys_clk) disable iff (reset)
        !(sfrRd & ~bitBad)
        |=> $stable(sfrRdata))
        else $error("read data changed without accepted read");

    a_swo_write: assert property (
        @(posedge sys_clk) disable iff (reset)
        (sfrWr & hitSysCtl & ~sfrBitMode)
        |=> (canSwitchOff == $past(sfrWdata[`SFAM_SWO_BIT])))
        else $error("switch-off bit not written");

    a_can_window: assert property (
        @(posedge sys_clk) disable iff (reset)
        canSel
        |-> (xdataAddr[15:8] == 8'hF7))
        else $error("can window decode wrong");

    a_can_hit: assert property (
        @(posedge sys_clk) disable iff (reset)
        (xdataReq & (xdataAddr[15:8] == 8'hF7))
        |-> canSel)
        else $error("can window access missed");

    a_count_total: assert property (
        @(posedge sys_clk) disable iff (reset)
        access
        |-> $onehot({mapSel, stdSel, sysCtlHit & ~bitBad, sfrBitError}))
        else $error("access not routed to exactly one place");

    a_select_pos: assert property (
        @(posedge sys_clk) disable iff (reset)
        (sfrWr & hitSysCtl & ~sfrBitMode)
        |=> (mapAreaSelect == $past(sfrWdata[`SFAM_MAP_BIT])))
        else $error("select bit position wrong");

    a_reserved_bits: assert property (
        @(posedge sys_clk) disable iff (reset)
        $stable(systemControl[7:6]))
        else $error("reserved control bits changed");

    a_sysctl_read: assert property (
        @(posedge sys_clk) disable iff (reset)
        (sfrRd & hitSysCtl & ~sfrBitMode)
        |=> (sfrRdata == $past(systemControl)))
        else $error("control register read wrong");

    a_new_select: assert property (
        @(posedge sys_clk) disable iff (reset)
        (sfrWr & hitSysCtl & ~sfrBitMode & sfrWdata[`SFAM_MAP_BIT])
        ##1 (access & mapHit & ~hitSysCtl & ~sfrBitMode) |-> mapSel)
        else $error("new area not used at once");

    c_map_access: cover property (
        @(posedge sys_clk) disable iff (reset) mapSel);
    c_bit_write: cover property (
        @(posedge sys_clk) disable iff (reset) sfrWr & sfrBitMode & hitSysCtl);
    c_can_hit: cover property (
        @(posedge sys_clk) disable iff (reset) canSel);
    c_switch_off: cover property (
        @(posedge sys_clk) disable iff (reset) $rose(canSwitchOff));
    c_bit_refused: cover property (
        @(posedge sys_clk) disable iff (reset) sfrBitError);
endmodule : sfam_decoder
`default_nettype wire

/* File: tb/sfam_area_model.sv */
// Purpose: stand-in for the standard and mapped register areas
// Assumes: area read data follows the strobes combinationally
// Notes: an unselected area shows a value unlike its selected one
`timescale 1ns/1ps
`default_nettype none
module sfam_area_model
    import sfam_pkg::*;
(
    // strobes from the decoder
    input wire logic stdSel,
    input wire logic mapSel,
    input wire logic [2:0] mapIndex,
    // read data back to the decoder
    output logic [7:0] stdRdata,
    output logic [7:0] mapRdata
);
    assign stdRdata = stdSel ? 8'h5A : 8'hC3;
    // index sits in the low bits so each mapped register reads apart
    assign mapRdata = mapSel ? {5'h14, mapIndex} : 8'h3C;
endmodule : sfam_area_model
`default_nettype wire

/* File: tb/sfr_area_map_select_tb.sv */
// Purpose: self-checking bench for the area decoder
// Assumes: inputs change at the rising edge by nonblocking assignment
// Notes: area read data comes from the area model
`timescale 1ns/1ps
`default_nettype none
module sfr_area_map_select_tb
    import sfam_pkg::*;
;
    logic sys_clk = 0, reset = 1, sfrRd = 0, sfrWr = 0, sfrBitMode = 0, sfrBitValue = 0, xdataReq = 0;
    logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00;
    logic [2:0] sfrBitIndex = 3'h0;
    logic [15:0] xdataAddr = 16'h0000;
    logic [7:0] sfrRdata, stdRdata, mapRdata, canOffset, systemControl;
    logic [2:0] mapIndex, areaSel;
    logic sfrBitRdata, sfrBitError, stdSel, mapSel, canSel, mapAreaSelect, canSwitchOff;
    int nFail = 0, checks = 0;
    logic [7:0] mapAddr [5] = '{8'h88, 8'h90, 8'hFC, 8'hFD, 8'hFE};
    logic [15:0] xAddr [4] = '{16'hF6FF, 16'hF700, 16'hF7FF, 16'hF800};
    logic xHit [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    sfam_decoder dut (.sys_clk, .reset, .sfrRd, .sfrWr, .sfrAddr, .sfrWdata, .sfrBitMode, .sfrBitIndex,
        .sfrBitValue, .sfrRdata, .sfrBitRdata, .sfrBitError, .stdRdata, .mapRdata, .stdSel, .mapSel,
        .mapIndex, .areaSel, .xdataReq, .xdataAddr, .canSel, .canOffset, .mapAreaSelect, .canSwitchOff,
        .systemControl);
    sfam_area_model areas (.stdSel, .mapSel, .mapIndex, .stdRdata, .mapRdata);
    always #12.5 sys_clk = ~sys_clk;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            nFail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic acc(input logic rd, input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        sfrRd <= rd;
        sfrWr <= !rd;
        sfrAddr <= a;
        sfrWdata <= d;
        #1;
    endtask : acc
    task automatic idle;
        @(posedge sys_clk);
        sfrRd <= 1'b0;
        sfrWr <= 1'b0;
        #1;
    endtask : idle
    task automatic test_map;
        acc(0, 8'hB1, 8'h10);
        acc(1, 8'h88, 8'h00);
        chk(mapAreaSelect, 1'b1);
        chk({mapSel, stdSel, areaSel, mapIndex}, {5'b10100, 3'h0});
        foreach (mapAddr[i]) begin
            acc(1, mapAddr[i], 8'h00);
            chk({mapSel, areaSel, mapIndex}, {4'b1100, 3'(i)});
        end
        idle;
        chk(sfrRdata, 8'hA4);
        chk(mapAreaSelect, 1'b1);
        acc(0, 8'hB1, 8'h00);
        acc(1, 8'h88, 8'h00);
        chk({mapSel, stdSel, areaSel}, 5'b01010);
        idle;
        chk(sfrRdata, 8'h5A);
        $display("test_map done");
    endtask : test_map
    task automatic test_can_off;
        acc(0, 8'hB1, 8'hC4);
        idle;
        chk({canSwitchOff, systemControl}, {1'b1, 8'h04});
        acc(1, 8'hB1, 8'h00);
        idle;
        chk(sfrRdata, 8'h04);
        acc(0, 8'hB1, 8'h00);
        idle;
        chk(canSwitchOff, 1'b0);
        $display("test_can_off done");
    endtask : test_can_off
    task automatic test_xdata;
        foreach (xAddr[i]) begin
            @(posedge sys_clk);
            xdataReq <= 1'b1;
            xdataAddr <= xAddr[i];
            #1;
            chk({canSel, canOffset}, {xHit[i], xAddr[i][7:0]});
        end
        $display("test_xdata done");
    endtask : test_xdata
    task automatic test_bit;
        acc(1, 8'h89, 8'h00);
        @(posedge sys_clk);
        sfrBitMode <= 1'b1;
        sfrBitIndex <= 3'h4;
        sfrBitValue <= 1'b1;
        #1;
        chk(sfrRdata, 8'h5A);
        chk({sfrBitError, stdSel, mapSel}, 3'b100);
        acc(1, 8'h88, 8'h00);
        chk({sfrRdata, sfrBitError, stdSel}, {8'h5A, 2'b01});
        acc(0, 8'hB1, 8'hFF);
        chk({sfrBitRdata, sfrBitError, stdSel, mapSel}, 4'b1100);
        idle;
        chk(systemControl, 8'h00);
        @(posedge sys_clk);
        sfrBitMode <= 1'b0;
        sfrBitValue <= 1'b0;
        #1;
        $display("test_bit done");
    endtask : test_bit
    task automatic finish_test;
        $display("checks %0d failures %0d", checks, nFail);
        if (nFail == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    initial begin
        #200000;
        nFail++;
        finish_test();
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        chk(systemControl, 8'h21);
        reset <= 1'b0;
        #1;
        chk({mapAreaSelect, canSwitchOff}, 2'b00);
        test_map();
        test_can_off();
        test_xdata();
        test_bit();
        finish_test();
    end
endmodule : sfr_area_map_select_tb
`default_nettype wire
